// ---- logic/dtc_pkg.sv ----
// constants, types and register map of the dual timer/counter pair
`default_nettype none
package dtc_pkg;
	// ****************************************************************
	// register map (byte addresses, one word each)
	// ****************************************************************
	localparam logic [7:0] DTC_OFF_CTRL = 8'h00;
	localparam logic [7:0] DTC_OFF_T0_LOW = 8'h04;
	localparam logic [7:0] DTC_OFF_T0_HIGH = 8'h08;
	localparam logic [7:0] DTC_OFF_T1_LOW = 8'h0C;
	localparam logic [7:0] DTC_OFF_T1_HIGH = 8'h10;
	localparam logic [7:0] DTC_OFF_STATUS = 8'h14;
	localparam logic [7:0] DTC_OFF_INT_CLR = 8'h18;
	localparam logic [7:0] DTC_OFF_INT_EN = 8'h1C;
	// ****************************************************************
	// widths, field positions, reset values, timing
	// ****************************************************************
	localparam int DTC_NUM_TIMERS = 2;
	localparam int DTC_CTL_W = 4;
	localparam int DTC_NUM_EVENTS = 3;
	localparam int DTC_EV_T0 = 0;
	localparam int DTC_EV_T1 = 1;
	localparam int DTC_EV_T0_HIGH = 2;
	localparam int DTC_PRE_W = 5;
	localparam logic [4:0] DTC_PRE_MAX = 5'h1F;
	localparam logic [7:0] DTC_BYTE_MAX = 8'hFF;
	localparam logic [7:0] DTC_BYTE_ONE = 8'h01;
	localparam logic [7:0] DTC_BYTE_RST = 8'h00;
	localparam logic [2:0] DTC_EV_RST = 3'h0;
	localparam logic [31:0] DTC_WORD_ZERO = 32'h00000000;
	// peripheral clocks per machine cycle
	localparam int DTC_MC_DIV = 2;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_t;
	typedef struct packed {
		logic run;
		logic ext_sel;
		dtc_mode_t mode;
	} dtc_ctl_t;
	localparam dtc_ctl_t DTC_CTL_RST = '{run: 1'b0, ext_sel: 1'b0,
		mode: DTC_MODE_13BIT};
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} dtc_count_t;
	typedef struct packed {
		logic wr_low;
		logic wr_high;
		logic [7:0] data;
	} dtc_wr_t;
endpackage
`default_nettype wire

// ---- logic/dtc_timer.sv ----
// one timer/counter core: count bytes, modes, overflow pulses
`default_nettype none
`timescale 1ns/1ps
module dtc_timer (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire dtc_pkg::dtc_mode_t i_mode,
	input wire logic i_inc,
	input wire logic i_inc_high,
	input wire dtc_pkg::dtc_wr_t i_wr,
	output dtc_pkg::dtc_count_t o_count,
	output logic o_ovf,
	output logic o_ovf_high
);
	import dtc_pkg::*;
	dtc_count_t cnt_q, cnt_d;
	logic ovf_q, ovf_d, ovh_q, ovh_d;
	logic carry;
	logic [4:0] pre;
	// ****************************************************************
	// next count
	// ****************************************************************
	always_comb begin
		cnt_d = cnt_q;
		ovf_d = 1'b0;
		ovh_d = 1'b0;
		carry = 1'b0;
		pre = cnt_q.low[DTC_PRE_W-1:0];
		if (i_inc) begin
			case (i_mode)
				DTC_MODE_13BIT: begin
					// prescaler in low bits feeds 8-bit high byte
					if (pre == DTC_PRE_MAX) begin
						cnt_d.low[DTC_PRE_W-1:0] = '0;
						{carry, cnt_d.high} = {1'b0, cnt_q.high} + 9'h001;
						ovf_d = carry;
					end else begin
						cnt_d.low[DTC_PRE_W-1:0] = 5'(pre + 5'h01);
					end
				end
				DTC_MODE_16BIT: begin
					{carry, cnt_d} = {1'b0, cnt_q} + 17'h00001;
					ovf_d = carry;
				end
				DTC_MODE_RELOAD: begin
					if (cnt_q.low == DTC_BYTE_MAX) begin
						cnt_d.low = cnt_q.high;
						ovf_d = 1'b1;
					end else begin
						cnt_d.low = cnt_q.low + DTC_BYTE_ONE;
					end
				end
				DTC_MODE_SPLIT: begin
					cnt_d.low = cnt_q.low + DTC_BYTE_ONE;
					ovf_d = (cnt_q.low == DTC_BYTE_MAX);
				end
				default: cnt_d = cnt_q;
			endcase
		end
		if (i_inc_high && i_mode == DTC_MODE_SPLIT) begin
			cnt_d.high = cnt_q.high + DTC_BYTE_ONE;
			ovh_d = (cnt_q.high == DTC_BYTE_MAX);
		end
		if (i_wr.wr_low)
			cnt_d.low = i_wr.data;
		if (i_wr.wr_high)
			cnt_d.high = i_wr.data;
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q <= '{high: DTC_BYTE_RST, low: DTC_BYTE_RST};
			ovf_q <= 1'b0;
			ovh_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
			ovh_q <= ovh_d;
		end
	end
	assign o_count = cnt_q;
	assign o_ovf = ovf_q;
	assign o_ovf_high = ovh_q;
endmodule // dtc_timer
`default_nettype wire

// ---- logic/dtc_top.sv ----
// dual timer/counter pair with apb registers and interrupt
// What this block does
// - timer function counts every two clocks
// - counter function counts falling edges of pin
// - four modes; timers independent in modes 0-2
// - mode zero: 8-bit counter after divide-by-32
// - mode one: bytes chained into 16-bit counter
// - mode two: low byte reloads from high
// - mode three: timer 0 two 8-bit counters
// - mode three freezes timer 1 count
// - timer 1 overflow gives baud tick
`default_nettype none
`timescale 1ns/1ps
module dtc_top (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_ext_count_input_0,
	input wire logic i_ext_count_input_1,
	output logic o_baud_tick,
	output logic o_irq
);
	import dtc_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	// ****************************************************************
	// machine cycle divider and pin synchronisers
	// ****************************************************************
	logic mc_q, mc_d, mc_tick;
	logic [1:0] pin_raw;
	logic [1:0] meta_q, sync_q, prev_q, ext_fall;
	assign pin_raw = {i_ext_count_input_1, i_ext_count_input_0};
	always_comb begin
		mc_d = ~mc_q;
	end
	assign mc_tick = mc_q; // one pulse every DTC_MC_DIV clocks
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mc_q <= 1'b0;
			meta_q <= 2'b11;
			sync_q <= 2'b11;
			prev_q <= 2'b11;
		end else begin
			mc_q <= mc_d;
			meta_q <= pin_raw;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	assign ext_fall = prev_q & ~sync_q; // 1-to-0 on pin

	// ****************************************************************
	// apb slave and registers
	// ****************************************************************
	dtc_ctl_t ctl_q [DTC_NUM_TIMERS];
	dtc_ctl_t ctl_d [DTC_NUM_TIMERS];
	logic [2:0] stat_q, stat_d, en_q, en_d, ev;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d, err_q, err_d, irq_q, irq_d, baud_q, baud_d;
	logic setup, access, wr, mapped;
	dtc_count_t cnt [DTC_NUM_TIMERS];
	dtc_wr_t twr [DTC_NUM_TIMERS];
	logic [1:0] inc, inc_high, ovf, ovf_high;

	assign setup = i_psel && !i_penable;
	assign access = i_psel && i_penable && ready_q;
	assign wr = access && i_pwrite;
	assign mapped = hit(i_paddr, DTC_OFF_CTRL) || hit(i_paddr, DTC_OFF_T0_LOW)
		|| hit(i_paddr, DTC_OFF_T0_HIGH) || hit(i_paddr, DTC_OFF_T1_LOW)
		|| hit(i_paddr, DTC_OFF_T1_HIGH) || hit(i_paddr, DTC_OFF_STATUS)
		|| hit(i_paddr, DTC_OFF_INT_CLR) || hit(i_paddr, DTC_OFF_INT_EN);
	assign twr[0] = '{wr_low: wr && hit(i_paddr, DTC_OFF_T0_LOW),
		wr_high: wr && hit(i_paddr, DTC_OFF_T0_HIGH), data: i_pwdata[7:0]};
	assign twr[1] = '{wr_low: wr && hit(i_paddr, DTC_OFF_T1_LOW),
		wr_high: wr && hit(i_paddr, DTC_OFF_T1_HIGH), data: i_pwdata[7:0]};
	assign ev = {ovf_high[0], ovf[1], ovf[0]};

	always_comb begin
		ready_d = setup;
		err_d = setup ? !mapped : err_q;
		rdata_d = rdata_q;
		if (setup) begin
			rdata_d = DTC_WORD_ZERO;
			if (!i_pwrite) begin
				if (hit(i_paddr, DTC_OFF_CTRL))
					rdata_d[2*DTC_CTL_W-1:0] = {ctl_q[1], ctl_q[0]};
				if (hit(i_paddr, DTC_OFF_T0_LOW))
					rdata_d[7:0] = cnt[0].low;
				if (hit(i_paddr, DTC_OFF_T0_HIGH))
					rdata_d[7:0] = cnt[0].high;
				if (hit(i_paddr, DTC_OFF_T1_LOW))
					rdata_d[7:0] = cnt[1].low;
				if (hit(i_paddr, DTC_OFF_T1_HIGH))
					rdata_d[7:0] = cnt[1].high;
				if (hit(i_paddr, DTC_OFF_STATUS))
					rdata_d[DTC_NUM_EVENTS-1:0] = stat_q;
				if (hit(i_paddr, DTC_OFF_INT_EN))
					rdata_d[DTC_NUM_EVENTS-1:0] = en_q;
			end
		end
		ctl_d = ctl_q;
		if (wr && hit(i_paddr, DTC_OFF_CTRL)) begin
			ctl_d[0] = dtc_ctl_t'(i_pwdata[DTC_CTL_W-1:0]);
			ctl_d[1] = dtc_ctl_t'(i_pwdata[2*DTC_CTL_W-1:DTC_CTL_W]);
		end
		en_d = en_q;
		if (wr && hit(i_paddr, DTC_OFF_INT_EN))
			en_d = i_pwdata[DTC_NUM_EVENTS-1:0];
		stat_d = stat_q;
		if (wr && hit(i_paddr, DTC_OFF_INT_CLR))
			stat_d = stat_q & ~i_pwdata[DTC_NUM_EVENTS-1:0];
		stat_d = stat_d | ev; // set wins over clear
		irq_d = |(stat_q & en_q);
		baud_d = ovf[1];
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctl_q[0] <= DTC_CTL_RST;
			ctl_q[1] <= DTC_CTL_RST;
			en_q <= DTC_EV_RST;
			stat_q <= DTC_EV_RST;
			rdata_q <= DTC_WORD_ZERO;
			ready_q <= 1'b0;
			err_q <= 1'b0;
			irq_q <= 1'b0;
			baud_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			en_q <= en_d;
			stat_q <= stat_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
			irq_q <= irq_d;
			baud_q <= baud_d;
		end
	end
	assign o_prdata = rdata_q;
	assign o_pready = ready_q;
	assign o_pslverr = err_q;
	assign o_irq = irq_q;
	assign o_baud_tick = baud_q;

	// ****************************************************************
	// timer cores
	// ****************************************************************
	// timer 1 halts in split mode; timer 0 high byte borrows its run bit
	assign inc_high[0] = ctl_q[1].run && mc_tick;
	assign inc_high[1] = 1'b0;
	generate
		for (genvar t = 0; t < DTC_NUM_TIMERS; t++) begin : g_tmr
			logic src;
			logic halt;
			assign src = ctl_q[t].ext_sel ? ext_fall[t] : mc_tick;
			assign halt = (t == 1) && (ctl_q[t].mode == DTC_MODE_SPLIT);
			assign inc[t] = ctl_q[t].run && src && !halt;
			dtc_timer u_timer (
				.i_clk(i_clk),
				.i_resetn(i_resetn),
				.i_mode(ctl_q[t].mode),
				.i_inc(inc[t]),
				.i_inc_high(inc_high[t]),
				.i_wr(twr[t]),
				.o_count(cnt[t]),
				.o_ovf(ovf[t]),
				.o_ovf_high(ovf_high[t])
			);
		end
	endgenerate

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	logic quiet0, quiet1, pend;
	logic [2*DTC_CTL_W-1:0] wr_ctl;
	logic [DTC_NUM_EVENTS-1:0] wr_bits;
	assign quiet0 = !twr[0].wr_low && !twr[0].wr_high;
	assign quiet1 = !twr[1].wr_low && !twr[1].wr_high;
	assign pend = |(stat_q & en_q);
	assign wr_ctl = i_pwdata[2*DTC_CTL_W-1:0];
	assign wr_bits = i_pwdata[DTC_NUM_EVENTS-1:0];
	sequence s_t0_tick16;
		inc[0] && ctl_q[0].mode == DTC_MODE_16BIT && quiet0;
	endsequence
	sequence s_bus_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_ctl_write;
		wr && hit(i_paddr, DTC_OFF_CTRL);
	endsequence
	sequence s_clr_write;
		wr && hit(i_paddr, DTC_OFF_INT_CLR) && ev == DTC_EV_RST;
	endsequence
	sequence s_flag_irq;
		stat_q[DTC_EV_T0] ##1 o_irq;
	endsequence
	sequence s_baud_late;
		o_baud_tick == 1'b0 ##1 o_baud_tick;
	endsequence

	// ****************************************************************
	// bus and flag checks
	// ****************************************************************
	AST_READY_ONE: assert property (
		s_bus_setup |=> o_pready ##1 !o_pready)
		else $error("ready not a single pulse after setup");
	AST_ERR_MAP: assert property (
		(i_psel && !i_penable && !mapped) |=> o_pslverr)
		else $error("unmapped address not flagged");
	AST_CTRL_WRITE: assert property (
		s_ctl_write |=> {ctl_q[1], ctl_q[0]} == $past(wr_ctl))
		else $error("control write did not land");
	AST_CLEAR: assert property (
		s_clr_write |=> (stat_q & $past(wr_bits)) == DTC_EV_RST)
		else $error("status bits not cleared");
	AST_SET_WINS: assert property (
		(ev != DTC_EV_RST) |=> (stat_q & $past(ev)) == $past(ev))
		else $error("overflow did not set its flag");
	AST_FLAG_IRQ: assert property (
		(ev[DTC_EV_T0] && en_q[DTC_EV_T0] && $stable(en_q))
		|=> s_flag_irq)
		else $error("overflow flag or interrupt missing");
	AST_IRQ_LEVEL: assert property (o_irq == $past(pend))
		else $error("interrupt does not follow enabled flags");
	AST_BAUD_SRC: assert property (o_baud_tick == $past(ovf[1]))
		else $error("baud tick not from timer 1 overflow");

	// ****************************************************************
	// counting checks
	// ****************************************************************
	AST_MC_RATE: assert property (mc_tick |=> !mc_tick ##1 mc_tick)
		else $error("machine cycle tick not every two clocks");
	AST_TIMER_STEP: assert property (
		(s_t0_tick16 and !ctl_q[0].ext_sel)
		|=> cnt[0] == 16'($past(cnt[0]) + 16'h0001))
		else $error("timer did not advance by one");
	AST_TIMER_GAP: assert property (
		(!ctl_q[0].ext_sel && !mc_tick && quiet0) |=> $stable(cnt[0]))
		else $error("timer moved between machine cycles");
	AST_EXT_EDGE: assert property (
		(ctl_q[0].run && ctl_q[0].ext_sel && ext_fall[0]
		&& ctl_q[0].mode == DTC_MODE_16BIT && quiet0)
		|=> cnt[0] == 16'($past(cnt[0]) + 16'h0001))
		else $error("falling edge not counted");
	AST_EXT_IDLE: assert property (
		(ctl_q[0].ext_sel && !ext_fall[0] && quiet0
		&& ctl_q[0].mode != DTC_MODE_SPLIT) |=> $stable(cnt[0]))
		else $error("counter moved without a falling edge");
	AST_INDEPENDENT: assert property (
		(!inc[1] && quiet1) |=> $stable(cnt[1]))
		else $error("timer 1 moved without its own cause");
	AST_RUN_OFF: assert property (
		(!ctl_q[0].run && quiet0) |=> $stable(cnt[0].low))
		else $error("stopped timer counted");
	AST_RUN_OFF1: assert property (
		(!ctl_q[1].run && quiet1) |=> $stable(cnt[1]))
		else $error("stopped timer 1 counted");

	// ****************************************************************
	// mode checks
	// ****************************************************************
	AST_PRESCALE: assert property (
		(inc[0] && quiet0 && ctl_q[0].mode == DTC_MODE_13BIT
		&& cnt[0].low[DTC_PRE_W-1:0] != DTC_PRE_MAX)
		|=> $stable(cnt[0].high))
		else $error("high byte moved before prescaler wrapped");
	AST_PRE_WRAP: assert property (
		(inc[0] && quiet0 && ctl_q[0].mode == DTC_MODE_13BIT
		&& cnt[0].low[DTC_PRE_W-1:0] == DTC_PRE_MAX)
		|=> cnt[0].low[DTC_PRE_W-1:0] == 5'h00
		&& cnt[0].high == 8'($past(cnt[0].high) + DTC_BYTE_ONE))
		else $error("prescaler wrap did not step high byte");
	AST_CARRY: assert property (
		(s_t0_tick16 and cnt[0] == 16'hFFFF)
		|=> cnt[0] == 16'h0000 ##1 stat_q[DTC_EV_T0])
		else $error("16-bit wrap did not carry out");
	AST_16_HOLD: assert property (
		(s_t0_tick16 and cnt[0].low != DTC_BYTE_MAX)
		|=> $stable(cnt[0].high))
		else $error("high byte moved without a carry");
	AST_RELOAD: assert property (
		(inc[1] && quiet1 && ctl_q[1].mode == DTC_MODE_RELOAD
		&& cnt[1].low == DTC_BYTE_MAX)
		|=> cnt[1].low == $past(cnt[1].high) ##0 s_baud_late)
		else $error("reload or baud tick wrong");
	AST_RELOAD_STEP: assert property (
		(inc[1] && quiet1 && ctl_q[1].mode == DTC_MODE_RELOAD
		&& cnt[1].low != DTC_BYTE_MAX)
		|=> cnt[1].low == 8'($past(cnt[1].low) + DTC_BYTE_ONE))
		else $error("reload counter did not step");
	AST_RELOAD_KEEP: assert property (
		(ctl_q[1].mode == DTC_MODE_RELOAD && quiet1) |=> $stable(cnt[1].high))
		else $error("reload value changed by counting");
	AST_SPLIT: assert property (
		(ctl_q[0].mode == DTC_MODE_SPLIT && !inc_high[0] && quiet0)
		|=> $stable(cnt[0].high))
		else $error("split high byte moved without its tick");
	AST_SPLIT_HIGH: assert property (
		(ctl_q[0].mode == DTC_MODE_SPLIT && inc_high[0] && quiet0)
		|=> cnt[0].high == 8'($past(cnt[0].high) + DTC_BYTE_ONE))
		else $error("split high byte did not step");
	AST_FREEZE: assert property (
		(ctl_q[1].mode == DTC_MODE_SPLIT && quiet1)
		|=> $stable(cnt[1]) && !ovf[1])
		else $error("timer 1 counted in split mode");
	AST_FREEZE_BAUD: assert property (
		(ctl_q[1].mode == DTC_MODE_SPLIT) |-> ##2 !o_baud_tick)
		else $error("baud tick while timer 1 frozen");
endmodule // dtc_top
`default_nettype wire

// ---- testbench/dtc_pin_src.sv ----
// falling-edge source standing in for an external count pin
`default_nettype none
`timescale 1ns/1ps
module dtc_pin_src (
	output logic o_pin,
	input wire logic i_clk
);
	// pin idles high between bursts
	initial o_pin = 1'b1;
	// n falling edges, low held hold clocks, high held hold+1 clocks between pulses
	task automatic pulse(input int n, input int hold);
		repeat (n) begin
			@(posedge i_clk);
			o_pin <= 1'b0;
			repeat (hold) @(posedge i_clk);
			o_pin <= 1'b1;
			repeat (hold) @(posedge i_clk);
		end
	endtask
endmodule // dtc_pin_src
`default_nettype wire

// ---- testbench/dtc_top_tb.sv ----
// self-checking bench for the dual timer/counter pair
`default_nettype none
`timescale 1ns/1ps
module dtc_top_tb;
	import dtc_pkg::*;
	logic i_clk, i_resetn, psel, penable, pwrite, pready, pslverr, err;
	logic pin0, pin1, baud, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	int baud_cnt = 0;
	dtc_top dtc_top_inst (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr),
		.i_ext_count_input_0(pin0), .i_ext_count_input_1(pin1),
		.o_baud_tick(baud), .o_irq(irq));
	dtc_pin_src dtc_pin_src_inst0 (.o_pin(pin0), .i_clk(i_clk));
	dtc_pin_src dtc_pin_src_inst1 (.o_pin(pin1), .i_clk(i_clk));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// watchdog and baud tick counter, sampled mid-cycle
	always @(negedge i_clk) begin
		cycles++;
		if (baud === 1'b1) baud_cnt++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	// ****************************************************************
	// bus and compare tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic load(input logic [7:0] ctl, input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		apb(1'b1, DTC_OFF_CTRL, 32'h0);
		apb(1'b1, a, {24'h0, lo});
		apb(1'b1, a + 8'h04, {24'h0, hi});
		apb(1'b1, DTC_OFF_CTRL, {24'h0, ctl});
	endtask
	task automatic conclude;
		if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset;
		rdchk(DTC_OFF_CTRL, 32'h0);
		rdchk(DTC_OFF_STATUS, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check({rd[30:0], err}, 32'h1);
		check({31'h0, irq}, 32'h0);
	endtask
	task automatic t_mode1;
		apb(1'b1, DTC_OFF_INT_EN, 32'h1);
		load(8'h0D, DTC_OFF_T0_LOW, 8'hFE, 8'hFF);
		dtc_pin_src_inst0.pulse(3, 2);
		rdchk(DTC_OFF_T0_LOW, 32'h01);
		rdchk(DTC_OFF_T0_HIGH, 32'h00);
		rdchk(DTC_OFF_STATUS, 32'h1);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, DTC_OFF_INT_CLR, 32'h1);
		rdchk(DTC_OFF_STATUS, 32'h0);
	endtask
	task automatic t_mode0;
		load(8'h0C, DTC_OFF_T0_LOW, 8'hFE, 8'h05);
		dtc_pin_src_inst0.pulse(3, 7);
		rdchk(DTC_OFF_T0_LOW, 32'hE1);
		rdchk(DTC_OFF_T0_HIGH, 32'h06);
	endtask
	task automatic t_mode2;
		apb(1'b1, DTC_OFF_INT_EN, 32'h2);
		load(8'hE0, DTC_OFF_T1_LOW, 8'hFE, 8'hF0);
		dtc_pin_src_inst1.pulse(3, 2);
		rdchk(DTC_OFF_T1_LOW, 32'hF1);
		rdchk(DTC_OFF_STATUS, 32'h2);
		rdchk(DTC_OFF_T0_LOW, 32'hE1);
		check(baud_cnt, 32'h1);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, DTC_OFF_INT_CLR, 32'h2);
		rdchk(DTC_OFF_STATUS, 32'h0);
		rdchk(DTC_OFF_INT_CLR, 32'h0);
		@(negedge i_clk);
		check({31'h0, irq}, 32'h0);
	endtask
	task automatic t_mode3;
		apb(1'b1, DTC_OFF_T1_LOW, 32'h55);
		load(8'hFF, DTC_OFF_T0_LOW, 8'hFF, 8'h00);
		dtc_pin_src_inst0.pulse(2, 2);
		dtc_pin_src_inst1.pulse(3, 2);
		rdchk(DTC_OFF_T0_LOW, 32'h01);
		rdchk(DTC_OFF_T1_LOW, 32'h55);
		apb(1'b0, DTC_OFF_STATUS, 32'h0);
		check(rd & 32'h3, 32'h1);
		check(baud_cnt, 32'h1);
		apb(1'b0, DTC_OFF_T0_HIGH, 32'h0);
		check({31'h0, rd != 0 && rd < 256}, 32'h1);
	endtask
	task automatic t_timer;
		load(8'h09, DTC_OFF_T0_LOW, 8'h00, 8'h00);
		repeat (100) @(posedge i_clk);
		apb(1'b1, DTC_OFF_CTRL, 32'h01);
		rdchk(DTC_OFF_T0_HIGH, 32'h0);
		apb(1'b0, DTC_OFF_T0_LOW, 32'h0);
		check({31'h0, rd >= 50 && rd <= 53}, 32'h1);
	endtask
	initial begin
		i_resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_mode1();
		t_mode0();
		t_mode2();
		t_mode3();
		t_timer();
		conclude();
	end
endmodule // dtc_top_tb
`default_nettype wire
